//--- include/cfd_pkg.sv
// Purpose: shared constants and types of the compact instruction format decoder
// Assumes: 32-bit fetch words, 16-bit halfword granule, 6-bit major opcode
// Notes:   bit positions are the lsb of each field; widths are in bits
package cfd_pkg;
   // widths
   localparam int INSN_W    = 32;
   localparam int HALF_W    = 16;
   localparam int OPC_W     = 6;
   localparam int REG_W     = 5;
   localparam int SREG_W    = 3;
   localparam int IMM_W     = 26;
   localparam int MINOR_W   = 6;
   localparam int OTHER_W   = 5;
   localparam int BUF_DEPTH = 2;

   // major opcode position in a 32-bit word and in a halfword
   localparam int OPC32_LSB = 26;
   localparam int OPC16_LSB = 10;

   // 5-bit register fields of 32-bit formats
   localparam int RF1_LSB = 21;
   localparam int RF2_LSB = 16;
   localparam int RF3_LSB = 11;
   localparam int RF4_LSB = 6;

   // 3-bit specifiers and 5-bit fields of 16-bit formats
   localparam int SRF1_LSB   = 7;
   localparam int SRF2_LSB   = 4;
   localparam int SRF3_LSB   = 1;
   localparam int WRF_HI_LSB = 5;
   localparam int WRF_LO_LSB = 0;

   // immediate widths, right aligned
   localparam int IMM26_W = 26;
   localparam int IMM16_W = 16;
   localparam int IMM12_W = 12;
   localparam int IMM10_W = 10;

   // minor opcode and other field placement per 32-bit class
   localparam int MIN_R4_LSB  = 0;
   localparam int MIN_I16_LSB = 21;
   localparam int MIN_I16_W   = 5;
   localparam int MIN_I12_LSB = 12;
   localparam int MIN_I12_W   = 4;
   localparam int OTH_I12_LSB = 21;

   // isa mode value that selects compact decoding
   localparam logic ISA_COMPACT = 1'b1;

   // reset values of the opcode tables
   localparam logic [63:0]  SHORT_OPC_MAP_RST = 64'h0E0E0E0E0E0E0E0E;
   localparam logic [127:0] FMT32_MAP_RST     = 128'h0;

   // 3-bit specifier to register number
   localparam logic [7:0][REG_W-1:0] SREG_MAP = {
      5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h11, 5'h10
   };

   // 32-bit layout classes chosen by the major opcode
   typedef enum logic [1:0] {
      CFD_FMT_R4,
      CFD_FMT_I26,
      CFD_FMT_I16,
      CFD_FMT_I12
   } cfd_fmt_e;

   // halfword assembly states
   typedef enum logic {
      CFD_ASM_FIRST,
      CFD_ASM_SECOND
   } cfd_asm_e;
endpackage : cfd_pkg

//--- include/cfd_if.sv
// Purpose: carrier between the decoder and its two-entry fetch buffer
// Assumes: one clock, valid/ready handshake on both sides
// Notes:   store side is the buffer, user side is the decoder
`timescale 1ns/1ps
interface cfd_if #(
   parameter int W = 32
);
   logic         wr_valid;
   logic         wr_ready;
   logic [W-1:0] wr_data;
   logic         rd_valid;
   logic         rd_ready;
   logic [W-1:0] rd_data;

   modport store (
      input  wr_valid,
      input  wr_data,
      input  rd_ready,
      output wr_ready,
      output rd_valid,
      output rd_data
   );

   modport user (
      output wr_valid,
      output wr_data,
      output rd_ready,
      input  wr_ready,
      input  rd_valid,
      input  rd_data
   );
endinterface : cfd_if

//--- hw/cfd_buf.sv
// Purpose: two-entry buffer between fetch and the halfword sequencer
// Assumes: ready flags are registered so the fetch side sees flop outputs
// Notes:   a push and a pop in one cycle both take effect
`timescale 1ns/1ps
module cfd_buf
   import cfd_pkg::*;
#(
   parameter int W     = INSN_W,
   parameter int DEPTH = BUF_DEPTH
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic ce,
   cfd_if.store      bus
);
   // the pointer logic serves exactly two entries
   if (DEPTH != 2) begin : g_chk
      $error("cfd_buf supports DEPTH of 2 only");
   end

   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic              wp;
      logic              rp;
      logic [1:0]        cnt;
      logic              nfull;
      logic              nempty;
   } cfd_buf_s;

   cfd_buf_s st_reg;
   cfd_buf_s st_next;
   logic     push;
   logic     pop;

   // pointer and count update, flags registered from the next count
   always_comb begin
      st_next = st_reg;
      push    = bus.wr_valid && st_reg.nfull;
      pop     = bus.rd_ready && st_reg.nempty;
      if (push) begin
         st_next.mem[st_reg.wp] = bus.wr_data;
         st_next.wp             = ~st_reg.wp;
      end
      if (pop) begin
         st_next.rp = ~st_reg.rp;
      end
      st_next.cnt    = st_reg.cnt + {1'b0, push} - {1'b0, pop};
      st_next.nfull  = (st_next.cnt != 2'h2);
      st_next.nempty = (st_next.cnt != 2'h0);
   end

   // state register, frozen while ce is low
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign bus.wr_ready = st_reg.nfull;
   assign bus.rd_valid = st_reg.nempty;
   assign bus.rd_data  = st_reg.mem[st_reg.rp];
endmodule : cfd_buf

//--- hw/cfd_decoder.sv
// Purpose: front end decoder for mixed 16/32-bit compact instructions
// Assumes: fetch words arrive in ascending address order on ref_clk
// Notes:   big_endian is a pin and is synchronised; isa_mode is core logic
//          16-bit decode shows every candidate field
//
// Contract
// - accept a stream of 16-bit and 32-bit instructions
// - major opcode is the top 6 bits of either length
// - 32-bit register fields 5 bits; most 16-bit ones 3 bits, mapped
// - up to four register fields are extracted
// - each 5-bit register field has one fixed position
// - immediates right aligned for some 16-bit and 16/26-bit 32-bit forms
// - branch, load/store offsets and jump targets use the immediate path
// - other fields sit between immediate and minor opcode, first lowest; the code puts other at bits 25..21, above the minor
// - an undrawn empty field lies beside the minor opcode
// - length comes from the major opcode alone
// - 32-bit major opcode picks minor position and immediate alignment
// - big endian: first halfword bits 31..16, second 15..0
// - little endian: first halfword bits 15..0, second 31..16
// - 32-bit instruction is two halfwords, opcode halfword first
// - halfwords are processed in ascending address order
// - 5-bit register code maps linearly to register number
// - compact decoding only while isa mode is one, else 32-bit words
// - 3-bit specifier selects one of eight registers
`timescale 1ns/1ps
module cfd_decoder
   import cfd_pkg::*;
#(
   parameter logic [63:0]  SHORT_OPC_MAP = SHORT_OPC_MAP_RST,
   parameter logic [127:0] FMT32_MAP     = FMT32_MAP_RST
) (
   // clock, reset, enable
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   // mode inputs
   input  wire logic                 isa_mode,
   input  wire logic                 big_endian,
   // fetch side
   input  wire logic                 fetch_valid,
   input  wire logic [INSN_W-1:0]    fetch_data,
   output wire logic                 fetch_ready,
   // decode side
   output wire logic                 dec_valid,
   input  wire logic                 dec_ready,
   output wire logic [INSN_W-1:0]    dec_instr,
   output wire logic                 dec_short,
   output wire logic [OPC_W-1:0]     dec_major,
   output wire logic [REG_W-1:0]     dec_reg1,
   output wire logic [REG_W-1:0]     dec_reg2,
   output wire logic [REG_W-1:0]     dec_reg3,
   output wire logic [REG_W-1:0]     dec_reg4,
   output wire logic [REG_W-1:0]     dec_wide_hi,
   output wire logic [REG_W-1:0]     dec_wide_lo,
   output wire logic [IMM_W-1:0]     dec_imm,
   output wire logic [MINOR_W-1:0]   dec_minor,
   output wire logic [OTHER_W-1:0]   dec_other,
   output wire logic [1:0]           dec_fmt
);
   // a table of all ones would leave no 32-bit opcode at all
   if (SHORT_OPC_MAP == {64{1'b1}}) begin : g_chk
      $error("cfd_decoder needs at least one 32-bit major opcode");
   end

   typedef struct packed {
      // endian synchroniser
      logic [1:0]         be_sync;
      // held word sequencing
      logic [INSN_W-1:0]  word;
      logic               word_vld;
      logic               half_sel;
      cfd_asm_e           asm_st;
      logic [HALF_W-1:0]  pend;
      // output stage
      logic               out_vld;
      // decoded fields
      logic [INSN_W-1:0]  instr;
      logic               short_f;
      logic [OPC_W-1:0]   major;
      logic [REG_W-1:0]   reg1;
      logic [REG_W-1:0]   reg2;
      logic [REG_W-1:0]   reg3;
      logic [REG_W-1:0]   reg4;
      logic [REG_W-1:0]   wide_hi;
      logic [REG_W-1:0]   wide_lo;
      logic [IMM_W-1:0]   imm;
      logic [MINOR_W-1:0] minor;
      logic [OTHER_W-1:0] other;
      logic [1:0]         fmt;
   } cfd_dec_s;

   cfd_dec_s            st_reg;
   cfd_dec_s            st_next;

   // halfword selection
   logic [HALF_W-1:0]   earlier;
   logic [HALF_W-1:0]   later;
   logic [HALF_W-1:0]   cur_hw;

   // output handshake
   logic                can_emit;
   logic                emit;
   logic                emit_short;
   logic                take;

   // assembled word views
   logic [INSN_W-1:0]   emit_word;
   logic [HALF_W-1:0]   hw;
   logic [OPC_W-1:0]    opc32;
   cfd_fmt_e            fmt;

   // carrier to the buffer
   cfd_if #(.W(INSN_W)) fbus ();

   // fetch words wait here so a stalled consumer drops nothing
   cfd_buf #(
      .W     (INSN_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .ce      (ce),
      .bus     (fbus.store)
   );

   // pull a word only while none is held
   assign fbus.wr_valid = fetch_valid;
   assign fbus.wr_data  = fetch_data;
   assign fbus.rd_ready = !st_reg.word_vld;

   // halfword sequencing and assembly
   always_comb begin
      st_next         = st_reg;
      // endian pin through two flops
      st_next.be_sync = {st_reg.be_sync[0], big_endian};
      // halfword order of the held word follows the endian pin
      if (st_reg.be_sync[1]) begin
         earlier = st_reg.word[31:16];
         later   = st_reg.word[15:0];
      end else begin
         earlier = st_reg.word[15:0];
         later   = st_reg.word[31:16];
      end

      // halfword in turn
      cur_hw     = st_reg.half_sel ? later : earlier;

      // stage free when empty or taken
      can_emit   = !st_reg.out_vld || dec_ready;
      // nothing emitted by default
      emit       = 1'b0;
      emit_short = 1'b0;
      take       = 1'b0;
      emit_word  = '0;

      // a taken output clears
      if (can_emit) begin
         st_next.out_vld = 1'b0;
      end

      // one halfword per cycle, a whole word per cycle in legacy mode
      if (st_reg.word_vld && can_emit) begin
         if (isa_mode != ISA_COMPACT) begin
            // legacy mode: every fetch word is one instruction
            emit             = 1'b1;
            emit_word        = st_reg.word;
            take             = 1'b1;
            st_next.half_sel = 1'b0;
            st_next.asm_st   = CFD_ASM_FIRST;
         end else begin
            // second halfword frees the word
            take             = st_reg.half_sel;
            st_next.half_sel = ~st_reg.half_sel;
            // first halfword sets the length
            unique case (st_reg.asm_st)
               CFD_ASM_FIRST: begin
                  // length from the major opcode only
                  if (SHORT_OPC_MAP[cur_hw[HALF_W-1:OPC16_LSB]]) begin
                     emit       = 1'b1;
                     emit_short = 1'b1;
                     emit_word  = {{HALF_W{1'b0}}, cur_hw};
                  end else begin
                     // keep the opcode half
                     st_next.pend   = cur_hw;
                     st_next.asm_st = CFD_ASM_SECOND;
                  end
               end
               CFD_ASM_SECOND: begin
                  // opcode half leads
                  emit           = 1'b1;
                  emit_word      = {st_reg.pend, cur_hw};
                  st_next.asm_st = CFD_ASM_FIRST;
               end
            endcase
         end
      end

      // word used up
      if (take) begin
         st_next.word_vld = 1'b0;
         st_next.half_sel = 1'b0;
      end

      // load a new word once the held one is used up
      if (!st_reg.word_vld && fbus.rd_valid) begin
         st_next.word     = fbus.rd_data;
         st_next.word_vld = 1'b1;
      end

      // field extraction for the emitted instruction
      hw    = emit_word[HALF_W-1:0];
      opc32 = emit_word[INSN_W-1:OPC32_LSB];
      // class of a 32-bit opcode
      fmt   = cfd_fmt_e'(FMT32_MAP[{opc32, 1'b0} +: 2]);
      if (emit) begin
         // capture word and fields
         st_next.out_vld = 1'b1;
         st_next.instr   = emit_word;
         st_next.short_f = emit_short;
         if (emit_short) begin
            // 16-bit: all candidates
            st_next.major   = hw[HALF_W-1:OPC16_LSB];
            st_next.reg1    = SREG_MAP[hw[SRF1_LSB +: SREG_W]];
            st_next.reg2    = SREG_MAP[hw[SRF2_LSB +: SREG_W]];
            st_next.reg3    = SREG_MAP[hw[SRF3_LSB +: SREG_W]];
            st_next.reg4    = '0;
            st_next.wide_hi = hw[WRF_HI_LSB +: REG_W];
            st_next.wide_lo = hw[WRF_LO_LSB +: REG_W];
            st_next.imm     = {{(IMM_W-IMM10_W){1'b0}}, hw[IMM10_W-1:0]};
            st_next.minor   = {{(MINOR_W-1){1'b0}}, hw[0]};
            st_next.other   = '0;
            st_next.fmt     = 2'h0;
         end else begin
            // 32-bit: class picks the rest
            st_next.major   = opc32;
            st_next.reg1    = emit_word[RF1_LSB +: REG_W];
            st_next.reg2    = emit_word[RF2_LSB +: REG_W];
            st_next.reg3    = emit_word[RF3_LSB +: REG_W];
            st_next.reg4    = emit_word[RF4_LSB +: REG_W];
            st_next.wide_hi = '0;
            st_next.wide_lo = '0;
            st_next.fmt     = fmt;
            unique case (fmt)
               CFD_FMT_R4: begin
                  // spare bits beside the minor opcode read back in it
                  st_next.imm   = '0;
                  st_next.minor = emit_word[MIN_R4_LSB +: MINOR_W];
                  st_next.other = '0;
               end
               CFD_FMT_I26: begin
                  // jump target width
                  st_next.imm   = emit_word[IMM26_W-1:0];
                  st_next.minor = '0;
                  st_next.other = '0;
               end
               CFD_FMT_I16: begin
                  // minor above the register
                  st_next.imm   = {{(IMM_W-IMM16_W){1'b0}}, emit_word[IMM16_W-1:0]};
                  st_next.minor = {1'b0, emit_word[MIN_I16_LSB +: MIN_I16_W]};
                  st_next.other = '0;
               end
               CFD_FMT_I12: begin
                  // other above the minor
                  st_next.imm   = {{(IMM_W-IMM12_W){1'b0}}, emit_word[IMM12_W-1:0]};
                  st_next.minor = {2'h0, emit_word[MIN_I12_LSB +: MIN_I12_W]};
                  st_next.other = emit_word[OTH_I12_LSB +: OTHER_W];
               end
            endcase
         end
      end
   end

   // single state register, frozen while ce is low
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops
   assign fetch_ready = fbus.wr_ready;

   // decoded instruction fields
   assign dec_valid   = st_reg.out_vld;
   assign dec_instr   = st_reg.instr;
   assign dec_short   = st_reg.short_f;
   assign dec_major   = st_reg.major;
   assign dec_reg1    = st_reg.reg1;
   assign dec_reg2    = st_reg.reg2;
   assign dec_reg3    = st_reg.reg3;
   assign dec_reg4    = st_reg.reg4;
   assign dec_wide_hi = st_reg.wide_hi;
   assign dec_wide_lo = st_reg.wide_lo;
   assign dec_imm     = st_reg.imm;
   assign dec_minor   = st_reg.minor;
   assign dec_other   = st_reg.other;
   assign dec_fmt     = st_reg.fmt;
endmodule : cfd_decoder

//--- tb/cfd_decoder_asserts.sv
// Purpose: port checks of the compact format decoder
// Assumes: isa_mode changes only while the decoder is idle
// Notes:   bound into every cfd_decoder instance
`timescale 1ns/1ps
module cfd_decoder_asserts
   import cfd_pkg::*;
#(
   parameter logic [63:0]  SHORT_OPC_MAP = SHORT_OPC_MAP_RST,
   parameter logic [127:0] FMT32_MAP     = FMT32_MAP_RST
) (
   input wire logic               ref_clk,
   input wire logic               nrst,
   input wire logic               ce,
   input wire logic               isa_mode,
   input wire logic               fetch_ready,
   input wire logic               dec_valid,
   input wire logic               dec_ready,
   input wire logic [INSN_W-1:0]  dec_instr,
   input wire logic               dec_short,
   input wire logic [OPC_W-1:0]   dec_major,
   input wire logic [REG_W-1:0]   dec_reg1,
   input wire logic [REG_W-1:0]   dec_reg2,
   input wire logic [REG_W-1:0]   dec_reg3,
   input wire logic [REG_W-1:0]   dec_reg4,
   input wire logic [REG_W-1:0]   dec_wide_hi,
   input wire logic [REG_W-1:0]   dec_wide_lo,
   input wire logic [IMM_W-1:0]   dec_imm,
   input wire logic [MINOR_W-1:0] dec_minor,
   input wire logic [OTHER_W-1:0] dec_other,
   input wire logic [1:0]         dec_fmt
);
   // register number picked by a 3-bit specifier
   function automatic logic [REG_W-1:0] sreg(input logic [2:0] c);
      return (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
   endfunction : sreg

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // offered instructions by kind
   sequence s_offer;  dec_valid; endsequence
   sequence s_narrow; dec_valid && dec_short; endsequence
   sequence s_cwide;  dec_valid && !dec_short && isa_mode; endsequence
   sequence s_stall;  dec_valid && !dec_ready && ce; endsequence

   a_length_opc: assert property (s_offer ##0 isa_mode |->
      dec_short == SHORT_OPC_MAP[dec_major]) else $error("length not from opcode");
   a_major_top: assert property (s_offer |->
      dec_major == (dec_short ? dec_instr[15:10] : dec_instr[31:26])) else $error("major");
   a_narrow_half: assert property (s_narrow |-> dec_instr[31:16] == 16'h0000
      && dec_wide_hi == dec_instr[9:5] && dec_wide_lo == dec_instr[4:0]) else $error("half");
   a_narrow_regs: assert property (s_narrow |-> dec_reg1 == sreg(dec_instr[9:7])
      && dec_reg2 == sreg(dec_instr[6:4]) && dec_reg3 == sreg(dec_instr[3:1])
      && dec_minor == {5'h00, dec_instr[0]}) else $error("narrow fields");
   a_wide_regs: assert property (s_cwide |-> dec_reg1 == dec_instr[25:21]
      && dec_reg2 == dec_instr[20:16] && dec_reg3 == dec_instr[15:11]
      && dec_reg4 == dec_instr[10:6]) else $error("wide fields");
   a_fmt_opc: assert property (s_cwide |->
      dec_fmt == FMT32_MAP[{dec_major, 1'b0} +: 2]) else $error("class");
   a_imm_align: assert property (s_cwide |->
      (dec_fmt != 2'h1 || dec_imm == dec_instr[25:0])
      && (dec_fmt != 2'h2 || dec_imm == {10'h000, dec_instr[15:0]})
      && (dec_fmt != 2'h3 || dec_imm == {14'h0000, dec_instr[11:0]})) else $error("imm");
   a_other_pos: assert property (s_cwide ##0 dec_fmt == 2'h3 |->
      dec_other == dec_instr[25:21] && dec_minor == {2'h0, dec_instr[15:12]}) else $error("oth");
   a_stall_hold: assert property (s_stall |=> dec_valid
      && $stable(dec_instr) && $stable(dec_imm)) else $error("stall lost word");
   a_ce_freeze: assert property (!ce |=> $stable(dec_valid)
      && $stable(fetch_ready)) else $error("moved without ce");
endmodule : cfd_decoder_asserts

bind cfd_decoder cfd_decoder_asserts #(.SHORT_OPC_MAP(SHORT_OPC_MAP), .FMT32_MAP(FMT32_MAP))
   u_cfd_decoder_asserts (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .isa_mode(isa_mode),
   .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_ready(dec_ready),
   .dec_instr(dec_instr), .dec_short(dec_short), .dec_major(dec_major),
   .dec_reg1(dec_reg1), .dec_reg2(dec_reg2), .dec_reg3(dec_reg3), .dec_reg4(dec_reg4),
   .dec_wide_hi(dec_wide_hi), .dec_wide_lo(dec_wide_lo), .dec_imm(dec_imm),
   .dec_minor(dec_minor), .dec_other(dec_other), .dec_fmt(dec_fmt));

//--- tb/cfd_fetch_model.sv
// Purpose: fetch unit model offering words to the decoder
// Assumes: the bench fills words in ascending address order
// Notes:   slow inserts gaps; an idle bus toggles instead of holding
`timescale 1ns/1ps
module cfd_fetch_model
   import cfd_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic              slow,
   input  wire logic              fetch_ready,
   output logic                   fetch_valid,
   output logic [INSN_W-1:0]      fetch_data
);
   logic [INSN_W-1:0] words[$];
   logic              taken;

   initial begin
      fetch_valid = 1'b0;
      fetch_data  = '0;
      taken       = 1'b0;
   end

   // note each word the decoder accepted on this edge
   always @(posedge ref_clk) taken = fetch_valid && fetch_ready && ce && nrst;

   // hold a word until taken, then offer the next in address order
   always @(negedge ref_clk) begin
      if (taken || !fetch_valid) begin
         if (words.size() > 0 && !slow) begin
            fetch_data  <= words.pop_front();
            fetch_valid <= 1'b1;
         end else begin
            fetch_data  <= ~fetch_data;  // no stale word on a released bus
            fetch_valid <= 1'b0;
         end
      end
   end
endmodule : cfd_fetch_model

//--- tb/testbench.sv
// Purpose: self-checking bench of the compact format decoder
// Assumes: mode and endian change only while the pipe is empty
// Notes:   a queue model predicts every decoded instruction
`timescale 1ns/1ps
module testbench;
   import cfd_pkg::*;
   localparam logic [63:0]  SMAP = 64'h0E0E0E0E0E0E0E0E;
   localparam logic [127:0] FMAP = {8{16'h3900}};
   logic               ref_clk, nrst, ce, isa_mode, big_endian, dec_ready, slow;
   logic               fetch_valid, fetch_ready, dec_valid, dec_short;
   logic [INSN_W-1:0]  fetch_data, dec_instr;
   logic [OPC_W-1:0]   dec_major;
   logic [REG_W-1:0]   r1, r2, r3, r4, whi, wlo;
   logic [IMM_W-1:0]   dec_imm;
   logic [MINOR_W-1:0] dec_minor;
   logic [OTHER_W-1:0] dec_other;
   logic [1:0]         dec_fmt;
   logic [107:0]       exp_q[$], msk_q[$], e, m, g;
   int                 err_count, n_tests, rdy_mode;

   cfd_decoder #(.SHORT_OPC_MAP(SMAP), .FMT32_MAP(FMAP)) u_cfd_decoder (
      .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .isa_mode(isa_mode),
      .big_endian(big_endian), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
      .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_ready(dec_ready),
      .dec_instr(dec_instr), .dec_short(dec_short), .dec_major(dec_major),
      .dec_reg1(r1), .dec_reg2(r2), .dec_reg3(r3), .dec_reg4(r4), .dec_wide_hi(whi),
      .dec_wide_lo(wlo), .dec_imm(dec_imm), .dec_minor(dec_minor),
      .dec_other(dec_other), .dec_fmt(dec_fmt));
   cfd_fetch_model u_cfd_fetch_model (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .slow(slow),
      .fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch_data(fetch_data));

   // 8 ns clock
   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;

   function automatic logic [4:0] nreg(input logic [2:0] c);
      return (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
   endfunction : nreg

   // queue expected outputs of one instruction and the mask of defined fields
   task automatic expect_insn(input logic [31:0] w, input bit sh, input bit leg);
      logic [1:0]   cl;
      logic [25:0]  imm;
      logic [5:0]   mn;
      logic [107:0] mk;
      mk  = '1;
      cl  = (!sh && w[28:26] inside {3'h4, 3'h5, 3'h6}) ? 2'(w[28:26] - 3'h3) : 2'h0;
      imm = (cl == 2'h1) ? w[25:0] : (cl == 2'h2) ? {10'h000, w[15:0]} : {14'h0, w[11:0]};
      mn  = (cl == 2'h0) ? w[5:0] : (cl == 2'h1) ? 6'h00 :
            (cl == 2'h2) ? {1'b0, w[25:21]} : {2'h0, w[15:12]};
      if (!sh && cl == 2'h0) mk[38:13] = '0;
      if (leg) mk[68:0] = '0;
      msk_q.push_back(mk);
      if (sh) exp_q.push_back({16'h0, w[15:0], 1'b1, w[15:10], nreg(w[9:7]), nreg(w[6:4]),
         nreg(w[3:1]), 5'h00, w[9:5], w[4:0], 16'h0, w[9:0], 5'h00, w[0], 7'h00});
      else exp_q.push_back({w, 1'b0, w[31:26], w[25:6], 10'h000, imm, mn,
         (cl == 2'h3) ? w[25:21] : 5'h00, cl});
   endtask : expect_insn

   // build a random stream, predict it and hand the words to the fetch model
   task automatic run_stream(input bit isa, input bit be, input int n, input int mode);
      logic [15:0] hq[$];
      logic [31:0] w;
      logic [2:0]  lo;
      bit          sh;
      isa_mode   = isa;
      big_endian = be;
      repeat (4) @(negedge ref_clk);
      rdy_mode   = mode;  // endian settles under the previous pacing
      for (int i = 0; i < n || hq.size() % 2 == 1; i++) begin
         w  = $urandom;
         sh = isa && (i >= n || $urandom % 2);
         lo = sh ? 3'($urandom_range(3, 1)) : (w[28] ? 3'(4 + $urandom % 4) : 3'h0);
         if (!isa) begin
            u_cfd_fetch_model.words.push_back(w);
            expect_insn(w, 1'b0, 1'b1);
         end else if (sh) begin
            w[12:10] = lo;
            hq.push_back(w[15:0]);
            expect_insn({16'h0, w[15:0]}, 1'b1, 1'b0);
         end else begin
            w[28:26] = lo;
            hq.push_back(w[31:16]);
            hq.push_back(w[15:0]);
            expect_insn(w, 1'b0, 1'b0);
         end
      end
      for (int i = 0; i < hq.size(); i += 2)
         u_cfd_fetch_model.words.push_back(be ? {hq[i], hq[i+1]} : {hq[i+1], hq[i]});
   endtask : run_stream

   task automatic check_bit(input string name, input logic expv, input logic got);
      n_tests++;
      if (got !== expv) begin
         err_count++;
         $display("Error %s expected %b seen %b", name, expv, got);
      end
   endtask : check_bit

   // wait until every predicted instruction has been taken
   task automatic drain(input int lim);
      int k;
      k = 0;
      while (exp_q.size() > 0 && k < lim) begin
         @(negedge ref_clk);
         k++;
      end
      check_bit("pipe_empty", 1'b1, exp_q.size() == 0);
   endtask : drain

   // consumer and fetch pacing, random in mode 1, consumer stalled in mode 2
   always @(negedge ref_clk) begin
      ce        <= (rdy_mode != 1) || ($urandom % 8 != 0);
      dec_ready <= (rdy_mode == 0) || (rdy_mode == 1 && $urandom % 3 != 0);
      slow      <= (rdy_mode == 1) && ($urandom % 4 == 0);
   end

   // score each decoded instruction the consumer takes
   always @(posedge ref_clk) begin
      if (nrst && ce && dec_valid === 1'b1 && dec_ready) begin
         g = {dec_instr, dec_short, dec_major, r1, r2, r3, r4, whi, wlo, dec_imm, dec_minor,
              dec_other, dec_fmt};
         e = (exp_q.size() > 0) ? exp_q.pop_front() : ~g;
         m = (msk_q.size() > 0) ? msk_q.pop_front() : '1;
         n_tests++;
         if (((g ^ e) & m) !== 108'h0) begin
            err_count++;
            $display("Error decode expected %h seen %h", e & m, g & m);
         end
      end
   end

   task automatic complete_run();
      $display("Counts: %0d checks, %0d errors", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   // cut a hang short
   initial begin
      #(8 * 40000);
      err_count++;
      $display("Error watchdog expected done seen running");
      complete_run();
   end

   // main sequence
   initial begin
      nrst       = 1'b0;
      ce         = 1'b1;
      isa_mode   = 1'b1;
      big_endian = 1'b0;
      dec_ready  = 1'b1;
      slow       = 1'b0;
      rdy_mode   = 0;
      err_count  = 0;
      n_tests    = 0;
      void'($urandom(32'hD646C474));
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      nrst = 1'b1;
      run_stream(1'b1, 1'b0, 40, 0);
      drain(2000);
      run_stream(1'b1, 1'b1, 40, 1);
      drain(3000);
      run_stream(1'b0, 1'b0, 20, 1);
      drain(2000);
      run_stream(1'b1, 1'b0, 24, 2);
      repeat (30) @(negedge ref_clk);
      check_bit("fetch_ready_full", 1'b0, fetch_ready);
      check_bit("dec_valid_stalled", 1'b1, dec_valid);
      rdy_mode = 0;
      drain(2000);
      nrst = 1'b0;
      @(negedge ref_clk);
      check_bit("fetch_ready_rst", 1'b0, fetch_ready);
      check_bit("dec_valid_rst", 1'b0, dec_valid);
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      run_stream(1'b1, 1'b1, 16, 0);
      drain(2000);
      complete_run();
   end
endmodule : testbench
